// [design/apcr_regs.sv]
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// How it works
// - Nine 64-bit registers decoded in translation window
// - Capability header ID fields read-only zero
// - Max process ID width reads 0x14
// - Privileged and execute support read zero
// - Memory attributes supported at bit seven
// - Global invalidate, page align, queue depth read one
// - Request capacity read-only, resets to 0xF
// - Allocation read/write, rewritable any time
// - Translation enable rise invalidates whole cache
// - Memory attributes enable, smallest unit read/write
// - Process ID control three bits read/write
module apcr_regs
  import apcr_pkg::*;
#(
  parameter int CACHE_ENTRIES = 64
)
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Register port
  input wire logic [APCR_ADDR_W-1:0] ADDR_I,
  input wire logic [63:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [63:0] RDATA_O,
  output logic HIT_O,
  // Control outputs
  output logic [31:0] ALLOCATION_O,
  output logic TRANS_EN_O,
  output logic MEMORY_ATTRIBUTES_SUPPORTED_EN_O,
  output logic [4:0] STU_O,
  output logic PR_EN_O,
  output logic PR_RESET_O,
  output logic [15:0] FAIL_LOOPS_O,
  output logic [2:0] PID_CTRL_O,
  output logic [63:0] LINK_CTRL_O,
  output logic [63:0] LINK_EXT_CTRL_O,
  // Translation cache invalidation
  output logic INV_VALID_O,
  output logic [$clog2(CACHE_ENTRIES)-1:0] INV_INDEX_O,
  output logic INV_BUSY_O
);
  localparam int IDX_W = $clog2(CACHE_ENTRIES);

  ////////////////////////////////////////////////////////////////////////////
  // Constant read-only words
  localparam logic [63:0] EXT_CAP_WORD = {12'h000, CAPABILITY_VERSION_RST,
    PID_ECID_RST, PR_ECID_RST, TR_ECID_RST};
  localparam logic [63:0] TRANS_CAP_WORD = {19'h0_0000, MAXPID_RST,
    5'h00, 1'b0, 1'b0,
    25'h000_0000, 1'b1,
    1'b1, 1'b1, INVQD_RST};
  localparam logic [63:0] CAPACITY_WORD = {32'h0000_0000,
    PR_CAPACITY_RST};

  function automatic logic [63:0] merge(input logic [63:0] old,
    input logic [63:0] wd, input logic [63:0] mask);
    merge = (old & ~mask) | (wd & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire sel_ext_w = (ADDR_I == OFF_EXT_CAP_HDR);
  wire sel_cap_w = (ADDR_I == OFF_TRANS_CAP_HDR);
  wire sel_prc_w = (ADDR_I == OFF_PR_CAPACITY);
  wire sel_pra_w = (ADDR_I == OFF_PR_ALLOCATION);
  wire sel_tpc_w = (ADDR_I == OFF_TP_CONTROL);
  wire sel_pid_w = (ADDR_I == OFF_PID_CONTROL);
  wire sel_prs_w = (ADDR_I == OFF_PR_STATUS);
  wire sel_lnk_w = (ADDR_I == OFF_LINK_CONTROL);
  wire sel_lnx_w = (ADDR_I == OFF_LINK_EXT_CONTROL);
  wire sel_any_w = sel_ext_w | sel_cap_w | sel_prc_w | sel_pra_w |
    sel_tpc_w | sel_pid_w | sel_prs_w | sel_lnk_w | sel_lnx_w;

  logic [63:0] pra_q;
  logic [63:0] tpc_q;
  logic [63:0] pid_q;
  logic [63:0] prs_q;
  logic [63:0] lnk_q;
  logic [63:0] lnx_q;
  logic [63:0] rdata_q;
  logic hit_q;
  logic start_q;

  wire [63:0] tpc_d = merge(tpc_q, WDATA_I, MASK_TP_CTRL);
  wire trans_rise_w = WR_I && sel_tpc_w && !tpc_q[TRANS_EN_BIT] &&
    tpc_d[TRANS_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      pra_q <= '0;
      tpc_q <= '0;
      pid_q <= '0;
      prs_q <= RST_PR_STAT;
      lnk_q <= RST_LINK_CTRL;
      lnx_q <= '0;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= trans_rise_w;
      if (WR_I)
      begin
        if (sel_pra_w)
          pra_q <= merge(pra_q, WDATA_I, MASK_PR_ALLOC);
        if (sel_tpc_w)
          tpc_q <= tpc_d;
        if (sel_pid_w)
          pid_q <= merge(pid_q, WDATA_I, MASK_PID_CTRL);
        if (sel_prs_w)
          prs_q <= merge(prs_q, WDATA_I, MASK_PR_STAT_W);
        if (sel_lnk_w)
          lnk_q <= merge(lnk_q, WDATA_I, MASK_LINK_CTRL);
        if (sel_lnx_w)
          lnx_q <= merge(lnx_q, WDATA_I, MASK_LINK_EXT);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped addresses read zero
  logic [63:0] rd_mux_w;
  always_comb
  begin
    rd_mux_w = '0;
    if (sel_ext_w)
      rd_mux_w = EXT_CAP_WORD;
    if (sel_cap_w)
      rd_mux_w = TRANS_CAP_WORD;
    if (sel_prc_w)
      rd_mux_w = CAPACITY_WORD;
    if (sel_pra_w)
      rd_mux_w = pra_q;
    if (sel_tpc_w)
      rd_mux_w = tpc_q;
    if (sel_pid_w)
      rd_mux_w = pid_q;
    if (sel_prs_w)
      rd_mux_w = prs_q;
    if (sel_lnk_w)
      rd_mux_w = lnk_q;
    if (sel_lnx_w)
      rd_mux_w = lnx_q;
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      rdata_q <= '0;
      hit_q <= 1'b0;
    end
    else
    begin
      rdata_q <= RD_I ? rd_mux_w : '0;
      hit_q <= RD_I && sel_any_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Silent whole-table invalidation
  apcr_sweep_if #(.IDX_W(IDX_W)) sw_if ();
  assign sw_if.start = start_q;

  apcr_sweep #(
    .ENTRIES(CACHE_ENTRIES)
  ) u_sweep (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .sw(sw_if.sweep)
  );

  logic inv_valid_q;
  logic [IDX_W-1:0] inv_index_q;
  logic inv_busy_q;
  // Registered copies keep every top output on a flop
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      inv_valid_q <= 1'b0;
      inv_index_q <= '0;
      inv_busy_q <= 1'b0;
    end
    else
    begin
      inv_valid_q <= sw_if.inv_valid;
      inv_index_q <= sw_if.inv_index;
      inv_busy_q <= sw_if.busy | start_q;
    end
  end

  assign RDATA_O = rdata_q;
  assign HIT_O = hit_q;
  assign ALLOCATION_O = pra_q[31:0];
  assign TRANS_EN_O = tpc_q[TRANS_EN_BIT];
  assign MEMORY_ATTRIBUTES_SUPPORTED_EN_O = tpc_q[MEMORY_ATTRIBUTES_SUPPORTED_EN_BIT];
  assign STU_O = tpc_q[4:0];
  assign PR_EN_O = tpc_q[PR_ENABLE_BIT];
  assign PR_RESET_O = tpc_q[PR_RESET_BIT];
  assign FAIL_LOOPS_O = tpc_q[63:FAIL_LOOPS_LSB];
  // Firmware is expected to hold these steady after init
  assign PID_CTRL_O = pid_q[2:0];
  assign LINK_CTRL_O = lnk_q;
  assign LINK_EXT_CTRL_O = lnx_q;
  assign INV_VALID_O = inv_valid_q;
  assign INV_INDEX_O = inv_index_q;
  assign INV_BUSY_O = inv_busy_q;
endmodule // apcr_regs

// [design/apcr_pkg.sv]
package apcr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register word offsets (byte addresses)
  localparam int APCR_ADDR_W = 20;
  localparam logic [19:0] OFF_EXT_CAP_HDR = 20'h1_9800;
  localparam logic [19:0] OFF_TRANS_CAP_HDR = 20'h1_9808;
  localparam logic [19:0] OFF_PR_CAPACITY = 20'h1_9810;
  localparam logic [19:0] OFF_PR_ALLOCATION = 20'h1_9818;
  localparam logic [19:0] OFF_TP_CONTROL = 20'h1_9820;
  localparam logic [19:0] OFF_PID_CONTROL = 20'h1_9828;
  localparam logic [19:0] OFF_PR_STATUS = 20'h1_9840;
  localparam logic [19:0] OFF_LINK_CONTROL = 20'h1_9860;
  localparam logic [19:0] OFF_LINK_EXT_CONTROL = 20'h1_9870;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CAPABILITY_VERSION_LSB = 48;
  localparam int PID_ECID_LSB = 32;
  localparam int PR_ECID_LSB = 16;
  localparam int MAXPID_LSB = 40;
  localparam int PRIV_SUP_BIT = 34;
  localparam int EXEC_SUP_BIT = 33;
  localparam int MEMORY_ATTRIBUTES_SUPPORTED_SUP_BIT = 7;
  localparam int GINV_SUP_BIT = 6;
  localparam int PALIGN_BIT = 5;
  localparam int FAIL_LOOPS_LSB = 48;
  localparam int PR_RESET_BIT = 33;
  localparam int PR_ENABLE_BIT = 32;
  localparam int TRANS_EN_BIT = 15;
  localparam int MEMORY_ATTRIBUTES_SUPPORTED_EN_BIT = 14;
  localparam int PID_PRIV_EN_BIT = 2;
  localparam int PID_EXEC_EN_BIT = 1;
  localparam int PID_EN_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values of read-only fields
  localparam logic [3:0] CAPABILITY_VERSION_RST = 4'h0;
  localparam logic [15:0] PID_ECID_RST = 16'h0000;
  localparam logic [15:0] PR_ECID_RST = 16'h0000;
  localparam logic [15:0] TR_ECID_RST = 16'h0000;
  localparam logic [4:0] MAXPID_RST = 5'h14;
  localparam logic [4:0] INVQD_RST = 5'h01;
  localparam logic [31:0] PR_CAPACITY_RST = 32'h0000_000F;

  ////////////////////////////////////////////////////////////////////////////
  // Writable masks; all other bits are reserved
  localparam logic [63:0] MASK_PR_ALLOC = 64'h0000_0000_FFFF_FFFF;
  localparam logic [63:0] MASK_TP_CTRL = 64'hFFFF_0003_0000_C01F;
  localparam logic [63:0] MASK_PID_CTRL = 64'h0000_0000_0000_0007;
  localparam logic [63:0] MASK_PR_STAT_W = 64'h0000_0000_0000_0003;
  localparam logic [63:0] MASK_LINK_CTRL = 64'hFFFF_0FFF_FFFF_FFFF;
  localparam logic [63:0] MASK_LINK_EXT = 64'hF000_0000_0000_0000;
  localparam logic [63:0] RST_PR_STAT = 64'h0000_0000_0000_0100;
  localparam logic [63:0] RST_LINK_CTRL = 64'h0000_0000_FF00_0000;

  // Cycles taken by the table sweep per entry
  localparam int SWEEP_STEP_CYCLES = 1;

endpackage

// [design/apcr_sweep_if.sv]
`timescale 1ns/1ps
interface apcr_sweep_if #(parameter int IDX_W = 6);
  logic start;
  logic busy;
  logic inv_valid;
  logic [IDX_W-1:0] inv_index;

  modport ctrl (output start, input busy, input inv_valid, input inv_index);
  modport sweep (input start, output busy, output inv_valid,
    output inv_index);
endinterface

// [design/apcr_sweep.sv]
`timescale 1ns/1ps
module apcr_sweep
  import apcr_pkg::*;
#(
  parameter int ENTRIES = 64
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  apcr_sweep_if.sweep sw
);
  localparam int IDX_W = $clog2(ENTRIES);

  // Refused at elaboration: a one-entry table has no index bits
  if (ENTRIES < 2)
  begin : g_bad_entries
    $error("ENTRIES must be at least 2");
  end

  logic busy_q;
  logic [IDX_W-1:0] idx_q;
  wire last_w = (idx_q == IDX_W'(ENTRIES - 1));

  // A restart during a sweep begins again at entry zero
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      busy_q <= 1'b0;
      idx_q <= '0;
    end
    else if (sw.start)
    begin
      busy_q <= 1'b1;
      idx_q <= '0;
    end
    else if (busy_q)
    begin
      busy_q <= !last_w;
      idx_q <= last_w ? '0 : idx_q + 1'b1;
    end
  end

  assign sw.busy = busy_q;
  assign sw.inv_valid = busy_q;
  assign sw.inv_index = idx_q;
endmodule // apcr_sweep

// [tb/apcr_regs_monitor.sv]
`timescale 1ns/1ps
module apcr_regs_monitor
  import apcr_pkg::*;
#(
  parameter int CACHE_ENTRIES = 64
)
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Register port
  input wire logic [APCR_ADDR_W-1:0] ADDR_I,
  input wire logic [63:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [63:0] RDATA_O,
  input wire logic HIT_O,
  // Control outputs
  input wire logic [31:0] ALLOCATION_O,
  input wire logic TRANS_EN_O,
  input wire logic MEMORY_ATTRIBUTES_SUPPORTED_EN_O,
  input wire logic [4:0] STU_O,
  input wire logic [2:0] PID_CTRL_O,
  // Invalidation
  input wire logic INV_VALID_O,
  input wire logic [$clog2(CACHE_ENTRIES)-1:0] INV_INDEX_O,
  input wire logic INV_BUSY_O
);
  localparam int IW = $clog2(CACHE_ENTRIES);
  localparam logic [IW-1:0] LAST = IW'(CACHE_ENTRIES - 1);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  ////////////////////////////////////////////////////////////////////////////
  a_hdr_value: assert property (
    RD_I && ADDR_I == OFF_TRANS_CAP_HDR |=> RDATA_O == 64'h0000_1400_0000_00E1)
    else $error("capability header value wrong");
  a_ext_zero: assert property (
    RD_I && ADDR_I == OFF_EXT_CAP_HDR |=> RDATA_O == 64'h0 && HIT_O)
    else $error("extended header not zero");
  a_cap_value: assert property (
    RD_I && ADDR_I == OFF_PR_CAPACITY |=> RDATA_O == 64'hF)
    else $error("request capacity wrong");
  a_unmapped_zero: assert property (
    RD_I && ADDR_I == 20'h1_9830 |=> RDATA_O == 64'h0 && !HIT_O)
    else $error("unmapped read answered");
  a_alloc_out: assert property (
    WR_I && ADDR_I == OFF_PR_ALLOCATION |=> ALLOCATION_O == $past(WDATA_I[31:0]))
    else $error("allocation not taken");
  a_ctrl_fields: assert property (
    WR_I && ADDR_I == OFF_TP_CONTROL |=> STU_O == $past(WDATA_I[4:0])
    && MEMORY_ATTRIBUTES_SUPPORTED_EN_O == $past(WDATA_I[14]))
    else $error("control fields not taken");
  a_pid_bits: assert property (
    WR_I && ADDR_I == OFF_PID_CONTROL |=> PID_CTRL_O == $past(WDATA_I[2:0]))
    else $error("process id control not taken");
  a_sweep_start: assert property (
    WR_I && ADDR_I == OFF_TP_CONTROL && WDATA_I[15] && !TRANS_EN_O
    |-> ##2 INV_BUSY_O ##1 INV_VALID_O && INV_INDEX_O == '0)
    else $error("sweep did not start");
  // Restart two cycles back would break the step, so it is excluded
  a_sweep_step: assert property (
    INV_VALID_O && INV_INDEX_O != LAST && $past(TRANS_EN_O, 2)
    |=> INV_VALID_O && INV_INDEX_O == $past(INV_INDEX_O) + 1'b1)
    else $error("sweep index skipped");
  a_sweep_end: assert property (
    INV_VALID_O && INV_INDEX_O == LAST && $past(TRANS_EN_O) && TRANS_EN_O
    |=> !INV_VALID_O && !INV_BUSY_O)
    else $error("sweep did not stop");
endmodule // apcr_regs_monitor

bind apcr_regs apcr_regs_monitor #(.CACHE_ENTRIES(CACHE_ENTRIES)) u_mon (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .HIT_O(HIT_O),
  .ALLOCATION_O(ALLOCATION_O), .TRANS_EN_O(TRANS_EN_O),
  .MEMORY_ATTRIBUTES_SUPPORTED_EN_O(MEMORY_ATTRIBUTES_SUPPORTED_EN_O), .STU_O(STU_O), .PID_CTRL_O(PID_CTRL_O),
  .INV_VALID_O(INV_VALID_O), .INV_INDEX_O(INV_INDEX_O),
  .INV_BUSY_O(INV_BUSY_O));

// [tb/apcr_regs_tb.sv]
`timescale 1ns/1ps
module apcr_regs_tb
  import apcr_pkg::*;
;
  localparam int N = 8;
  localparam logic [63:0] HDR = 64'h0000_1400_0000_00E1;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [19:0] addr = '0;
  logic [63:0] wdata = '0;
  logic wstb = 1'b0;
  logic rstb = 1'b0;
  logic [63:0] rdata, link, link_ext;
  logic hit, trans_en, memory_attributes_supported_en, pr_en, pr_rst, inv_v, inv_b;
  logic [31:0] alloc;
  logic [4:0] stu;
  logic [15:0] loops;
  logic [2:0] pid;
  logic [$clog2(N)-1:0] inv_i;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [19:0] ad [9] = '{OFF_EXT_CAP_HDR, OFF_TRANS_CAP_HDR, OFF_PR_CAPACITY,
    OFF_PR_ALLOCATION, OFF_TP_CONTROL, OFF_PID_CONTROL, OFF_PR_STATUS,
    OFF_LINK_CONTROL, OFF_LINK_EXT_CONTROL};
  logic [63:0] rv [9] = '{64'h0, HDR, 64'hF, 64'h0, 64'h0, 64'h0, 64'h100,
    64'hFF00_0000, 64'h0};
  logic [63:0] ov [9] = '{64'h0, HDR, 64'hF, 64'hFFFF_FFFF,
    64'hFFFF_0003_0000_C01F, 64'h7, 64'h103, 64'hFFFF_0FFF_FFFF_FFFF,
    64'hF000_0000_0000_0000};

  apcr_regs #(.CACHE_ENTRIES(N)) u_apcr_regs (.CLK_I(clk), .RESET_I(rst),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wstb), .RD_I(rstb),
    .RDATA_O(rdata), .HIT_O(hit), .ALLOCATION_O(alloc),
    .TRANS_EN_O(trans_en), .MEMORY_ATTRIBUTES_SUPPORTED_EN_O(memory_attributes_supported_en), .STU_O(stu),
    .PR_EN_O(pr_en), .PR_RESET_O(pr_rst), .FAIL_LOOPS_O(loops),
    .PID_CTRL_O(pid), .LINK_CTRL_O(link), .LINK_EXT_CTRL_O(link_ext),
    .INV_VALID_O(inv_v), .INV_INDEX_O(inv_i), .INV_BUSY_O(inv_b));

  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [63:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wstb <= 1'b1;
    @(posedge clk);
    wstb <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [19:0] a, input logic [63:0] e,
    input logic h);
    @(posedge clk);
    addr <= a;
    rstb <= 1'b1;
    @(posedge clk);
    rstb <= 1'b0;
    #1;
    chk(rdata, e);
    chk(hit, h);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int i = 0; i < 9; i++)
      rd(ad[i], rv[i], 1'b1);
    rd(20'h1_9830, 64'h0, 1'b0);
    chk({loops, pr_rst, pr_en, trans_en, memory_attributes_supported_en, stu}, 25'h0);
    chk({pid, alloc, inv_b, inv_v}, 37'h0);
    chk(link, 64'hFF00_0000);
    chk(link_ext, 64'h0);
    $display("t_reset done");
  endtask

  // All ones everywhere: read-only and reserved bits must not move
  task automatic t_rw;
    for (int i = 0; i < 9; i++)
      wr(ad[i], '1);
    for (int i = 0; i < 9; i++)
      rd(ad[i], ov[i], 1'b1);
    chk({loops, pr_rst, pr_en, trans_en, memory_attributes_supported_en, stu},
      25'h1FF_FFFF);
    chk({pid, alloc}, 35'h7_FFFF_FFFF);
    chk(link, 64'hFFFF_0FFF_FFFF_FFFF);
    chk(link_ext, 64'hF000_0000_0000_0000);
    $display("t_rw done");
  endtask

  task automatic t_sweep;
    int n;
    n = 0;
    wr(OFF_TP_CONTROL, 64'h0);
    wr(OFF_TP_CONTROL, 64'h8000);
    repeat (3 * N)
    begin
      @(posedge clk);
      #1;
      if (inv_v === 1'b1)
      begin
        chk(inv_i, n);
        n++;
      end
    end
    chk(n, N);
    wr(OFF_TP_CONTROL, 64'h8000);
    repeat (6)
    begin
      @(posedge clk);
      #1;
      chk({inv_b, inv_v}, 2'b00);
    end
    $display("t_sweep done");
  endtask

  task automatic t_realloc;
    wr(OFF_PR_ALLOCATION, 64'hFFFF_FFFF_1234_5678);
    rd(OFF_PR_ALLOCATION, 64'h1234_5678, 1'b1);
    chk(alloc, 32'h1234_5678);
    $display("t_realloc done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      mismatches++;
      tally_and_finish;
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_rw;
    t_sweep;
    t_realloc;
    tally_and_finish;
  end
endmodule // apcr_regs_tb
